/* File: pkg/adc_seq_pkg.sv */
// Register map, field layout and codes shared by the conversion sequencer
package adc_seq_pkg;

	// Register byte offsets on the APB slave
	localparam logic [7:0] OFS_INPUT_ENABLE = 8'h00;
	localparam logic [7:0] OFS_CTRL_STATUS  = 8'h04;
	localparam logic [7:0] OFS_SEQ_CFG      = 8'h08;
	localparam logic [7:0] OFS_EXTRA_CFG    = 8'h0c;
	localparam logic [7:0] OFS_RESULT_LOW   = 8'h10;
	localparam logic [7:0] OFS_RESULT_HIGH  = 8'h14;

	// Control/status field positions
	localparam int CS_EOC_BIT   = 7;
	localparam int CS_ST_BIT    = 6;
	localparam int CS_START_SOURCE_SELECT_LSB = 4;
	localparam int CS_BUSY_BIT  = 0;

	// Sequence and extra configuration field positions (same coding)
	localparam int CFG_SREF_LSB = 6;
	localparam int CFG_SDIV_LSB = 4;
	localparam int CFG_SCH_LSB  = 0;

	// Reset values
	localparam logic [7:0] INPUT_ENABLE_RST = 8'h00;
	localparam logic [1:0] START_SOURCE_SELECT_RST        = 2'h3;
	localparam logic [7:0] SEQ_CFG_RST      = 8'h00;
	localparam logic [7:0] EXTRA_CFG_RST    = 8'h00;

	// Start source choices
	localparam logic [1:0] START_SOURCE_SELECT_EXT_PIN  = 2'h0;
	localparam logic [1:0] START_SOURCE_SELECT_SEQ_END  = 2'h1;
	localparam logic [1:0] START_SOURCE_SELECT_TIMER    = 2'h2;
	localparam logic [1:0] START_SOURCE_SELECT_SOFTWARE = 2'h3;

	// Channel codes
	localparam logic [3:0] CH_DIFF_FIRST     = 4'h8;
	localparam logic [3:0] CH_INTERNAL_FIRST = 4'hc;
	localparam logic [3:0] CH_GND            = 4'hc;
	localparam logic [3:0] CH_VREF           = 4'hd;
	localparam logic [3:0] CH_TEMP           = 4'he;
	localparam logic [3:0] CH_VDD_THIRD      = 4'hf;

	// Result width and resolution per decimation code
	localparam int         RESULT_W   = 12;
	localparam logic [3:0] RES_SDIV_0 = 4'h7;
	localparam logic [3:0] RES_SDIV_1 = 4'h9;
	localparam logic [3:0] RES_SDIV_2 = 4'ha;
	localparam logic [3:0] RES_SDIV_3 = 4'hc;

endpackage

/* File: hw/adc_result_format.sv */
// Truncates a raw conversion result to the resolution of its decimation rate
`timescale 1ns/1ps
module adc_result_format (
	// Decimation code of the finished conversion
	input  wire logic [1:0]                     sdiv,
	// Raw and truncated result, MSB aligned
	input  wire logic [adc_seq_pkg::RESULT_W-1:0] rawResult,
	output logic      [adc_seq_pkg::RESULT_W-1:0] result
);
	wire [3:0] resBits;
	wire [3:0] dropBits;
	wire [adc_seq_pkg::RESULT_W-1:0] keepMask;

	// Lower decimation rates give fewer meaningful bits
	assign resBits = (sdiv == 2'h0) ? adc_seq_pkg::RES_SDIV_0 :
		(sdiv == 2'h1) ? adc_seq_pkg::RES_SDIV_1 :
		(sdiv == 2'h2) ? adc_seq_pkg::RES_SDIV_2 :
		adc_seq_pkg::RES_SDIV_3;
	assign dropBits = 4'(adc_seq_pkg::RESULT_W) - resBits;
	assign keepMask = {adc_seq_pkg::RESULT_W{1'b1}} << dropBits;
	assign result   = rawResult & keepMask;
endmodule

/* File: hw/adc_conversion_sequencer.sv */
// Converter sequencer: APB registers, channel sequencing, extra conversion
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - An enable bit per port pin makes that pin a converter input.
// - All converter inputs are disabled after reset.
// - Channel codes: 0-7 single, 8-11 pairs, 12-15 internal sources.
// - Single-ended sequence runs from input 0 up to the programmed input.
// - Differential sequence runs from pair 0/1 up to the selected pair.
// - Codes 12 and up give one conversion of an internal source.
// - Inputs in range but not enabled are skipped.
// - A pair is converted only when both of its pins are enabled.
// - Pairs are 0/1, 2/3, 4/5, 6/7; their difference is converted.
// - The temperature sensor is a selectable converter input.
// - One third of the supply is a selectable converter input.
// - Sequence results reach memory by DMA with no CPU action.
// - One separately configured extra conversion may be requested.
// - Decimation rate sets result resolution, 7 to 12 bits.
// - Sequence conversions raise DMA triggers; extra conversions raise an interrupt.
// - End-of-conversion flag sets on completion, clears on high byte read.
// - Software start bit starts a sequence, clears itself at its end.
// - Start source: pin edge, sequence end, timer compare, software bit.
// - Channel readback gives last code plus one below 12, else the code; an extra conversion reads back its own code unchanged.
module adc_conversion_sequencer #(
	parameter int NUM_INPUTS = 8
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// APB slave
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Start sources
	input  wire logic                     extStartPin,
	input  wire logic                     timerCompare,
	// Pin configuration
	output logic      [NUM_INPUTS-1:0]    analogEnable,
	// Converter core
	output logic                          convStart,
	output logic      [3:0]               convChannel,
	output logic      [1:0]               convRef,
	output logic      [1:0]               convDecim,
	input  wire logic                     convDone,
	input  wire logic [adc_seq_pkg::RESULT_W-1:0] convData,
	// DMA and interrupt
	output logic      [NUM_INPUTS:0]      dmaChanTrig,
	output logic                          dmaAllTrig,
	output logic                          extraDoneIrq
);
	localparam int IDX_W = $clog2(NUM_INPUTS);

	typedef enum logic [1:0] {IDLE, PICK, BUSY_SEQ, BUSY_EXTRA} state_e;

	function automatic logic [3:0] readback(input logic [3:0] code);
		readback = (code < adc_seq_pkg::CH_INTERNAL_FIRST) ?
			code + 4'h1 : code;
	endfunction

	state_e                      state_q, state_d;
	logic [IDX_W-1:0]            idx_q, idx_d;
	logic [NUM_INPUTS-1:0]       enable_q, enablePrev_q;
	logic [1:0]                  start_source_select_q;
	logic                        st_q, eoc_q, extraPend_q, extPrev_q;
	logic [7:0]                  seqCfg_q, extraCfg_q;
	logic [3:0]                  schRead_q;
	logic [adc_seq_pkg::RESULT_W-1:0] result_q;
	logic                        pready_q, pslverr_q;
	logic [31:0]                 prdata_q;
	logic                        convStart_q;
	logic [3:0]                  convChannel_q;
	logic [1:0]                  convRef_q, convDecim_q;
	logic [NUM_INPUTS:0]         dmaChanTrig_q;
	logic                        dmaAllTrig_q, irq_q;
	logic                        issueSeq, launchExtra, seqComplete;

	// APB decode
	wire accessCyc = psel & penable & ~pready_q;
	wire doneCyc   = psel & penable & pready_q;
	wire wrDone    = doneCyc & pwrite;
	wire rdDone    = doneCyc & ~pwrite;
	wire hitEnable = paddr == adc_seq_pkg::OFS_INPUT_ENABLE;
	wire hitCs     = paddr == adc_seq_pkg::OFS_CTRL_STATUS;
	wire hitSeq    = paddr == adc_seq_pkg::OFS_SEQ_CFG;
	wire hitExtra  = paddr == adc_seq_pkg::OFS_EXTRA_CFG;
	wire hitLow    = paddr == adc_seq_pkg::OFS_RESULT_LOW;
	wire hitHigh   = paddr == adc_seq_pkg::OFS_RESULT_HIGH;
	wire mapped    = hitEnable | hitCs | hitSeq | hitExtra | hitLow | hitHigh;

	wire busy      = state_q != IDLE;
	wire [7:0] csRead = {eoc_q, st_q, start_source_select_q, 3'h0, busy};
	wire [7:0] seqRead = {seqCfg_q[7:4], schRead_q};
	wire [7:0] rdByte =
		hitEnable ? 8'(enable_q) :
		hitCs     ? csRead :
		hitSeq    ? seqRead :
		hitExtra  ? extraCfg_q :
		hitLow    ? {result_q[3:0], 4'h0} :
		hitHigh   ? result_q[11:4] : 8'h00;

	// Configuration fields
	wire [3:0] sequence_channel_field    = seqCfg_q[adc_seq_pkg::CFG_SCH_LSB +: 4];
	wire [3:0] extSch = extraCfg_q[adc_seq_pkg::CFG_SCH_LSB +: 4];
	wire isInternal = sequence_channel_field >= adc_seq_pkg::CH_INTERNAL_FIRST;
	wire isDiff     = (sequence_channel_field >= adc_seq_pkg::CH_DIFF_FIRST) & ~isInternal;

	// Pair usability, both pins enabled
	logic [NUM_INPUTS/2-1:0] pairOk;
	for (genvar p = 0; p < NUM_INPUTS/2; p++) begin : g_pair
		assign pairOk[p] = enable_q[2*p] & enable_q[2*p+1];
	end

	// Entry range and usability of the current sequence entry
	wire [IDX_W-1:0] lastIdx = isDiff ? IDX_W'(sequence_channel_field[1:0]) : sequence_channel_field[IDX_W-1:0];
	wire lastEntry = isInternal | (idx_q == lastIdx);
	wire entryUsable = isInternal ? 1'b1 :
		isDiff ? pairOk[idx_q[IDX_W-2:0]] :
		enable_q[idx_q];
	// Pairs use codes 8..11, single-ended use the input number
	wire [3:0] entryCode = isInternal ? sequence_channel_field :
		isDiff ? (adc_seq_pkg::CH_DIFF_FIRST | 4'(idx_q)) : 4'(idx_q);

	// Start sources
	wire extRise = extStartPin & ~extPrev_q;
	wire startEvent =
		(start_source_select_q == adc_seq_pkg::START_SOURCE_SELECT_EXT_PIN)  ? extRise :
		(start_source_select_q == adc_seq_pkg::START_SOURCE_SELECT_TIMER)    ? timerCompare :
		(start_source_select_q == adc_seq_pkg::START_SOURCE_SELECT_SOFTWARE) ? st_q :
		1'b0;
	wire chainStart = start_source_select_q == adc_seq_pkg::START_SOURCE_SELECT_SEQ_END;

	wire seqEnd   = (state_q == BUSY_SEQ) & convDone;
	wire extraEnd = (state_q == BUSY_EXTRA) & convDone;
	wire skipEnt  = (state_q == PICK) & ~entryUsable;
	wire [adc_seq_pkg::RESULT_W-1:0] fmtResult;

	adc_result_format u_fmt (
		.sdiv      (convDecim_q),
		.rawResult (convData),
		.result    (fmtResult)
	);

	// Sequencer, one conversion in flight at a time
	always_comb begin
		state_d     = state_q;
		idx_d       = idx_q;
		issueSeq    = 1'b0;
		launchExtra = 1'b0;
		seqComplete = 1'b0;
		case (state_q)
			IDLE: begin
				if (extraPend_q) begin
					launchExtra = 1'b1;
					state_d     = BUSY_EXTRA;
				end else if (startEvent) begin
					idx_d   = '0;
					state_d = PICK;
				end
			end
			PICK: begin
				if (entryUsable) begin
					issueSeq = 1'b1;
					state_d  = BUSY_SEQ;
				end else if (!lastEntry) begin
					idx_d = idx_q + 1'b1;
				end else begin
					seqComplete = 1'b1;
				end
			end
			BUSY_SEQ: begin
				if (convDone && !lastEntry) begin
					idx_d   = idx_q + 1'b1;
					state_d = PICK;
				end else if (convDone) begin
					seqComplete = 1'b1;
				end
			end
			BUSY_EXTRA: begin
				if (convDone)
					state_d = IDLE;
			end
			default: state_d = IDLE;
		endcase
		// Held extra request goes after the sequence
		if (seqComplete) begin
			if (extraPend_q) begin
				launchExtra = 1'b1;
				state_d     = BUSY_EXTRA;
			end else if (chainStart) begin
				idx_d   = '0;
				state_d = PICK;
			end else begin
				state_d = IDLE;
			end
		end
	end

	// Flag next values; a set in the same cycle as a clear wins
	wire csWrite  = wrDone & hitCs;
	wire stSet    = csWrite & pwdata[adc_seq_pkg::CS_ST_BIT];
	wire st_d     = stSet | (st_q & ~seqComplete);
	wire eocClear = rdDone & hitHigh;
	wire eoc_d    = seqEnd | extraEnd | (eoc_q & ~eocClear);
	wire extraWr  = wrDone & hitExtra;
	wire extraPend_d = extraWr | (extraPend_q & ~launchExtra);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q     <= IDLE;
			idx_q       <= '0;
			st_q        <= 1'b0;
			eoc_q       <= 1'b0;
			extraPend_q <= 1'b0;
			extPrev_q   <= 1'b0;
		end else begin
			state_q     <= state_d;
			idx_q       <= idx_d;
			st_q        <= st_d;
			eoc_q       <= eoc_d;
			extraPend_q <= extraPend_d;
			extPrev_q   <= extStartPin;
		end
	end

	// Software registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable_q   <= NUM_INPUTS'(adc_seq_pkg::INPUT_ENABLE_RST);
			start_source_select_q    <= adc_seq_pkg::START_SOURCE_SELECT_RST;
			seqCfg_q   <= adc_seq_pkg::SEQ_CFG_RST;
			extraCfg_q <= adc_seq_pkg::EXTRA_CFG_RST;
		end else begin
			if (wrDone && hitEnable)
				enable_q <= pwdata[NUM_INPUTS-1:0];
			if (csWrite)
				start_source_select_q <= pwdata[adc_seq_pkg::CS_START_SOURCE_SELECT_LSB +: 2];
			if (wrDone && hitSeq)
				seqCfg_q <= pwdata[7:0];
			if (extraWr)
				extraCfg_q <= pwdata[7:0];
		end
	end

	// Channel readback follows the last finished or skipped entry or finished extra conversion
	always_ff @(posedge clk) begin
		if (sys_rst)
			schRead_q <= 4'h0;
		else if (seqEnd || skipEnt)
			schRead_q <= readback(entryCode);
		else if (extraEnd)
			schRead_q <= convChannel_q;
		else if (wrDone && hitSeq)
			schRead_q <= pwdata[adc_seq_pkg::CFG_SCH_LSB +: 4];
	end

	// Converter command; internal codes reach the temperature sensor and
	// the supply third through the same channel field
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			convStart_q   <= 1'b0;
			convChannel_q <= 4'h0;
			convRef_q     <= 2'h0;
			convDecim_q   <= 2'h0;
		end else begin
			convStart_q <= issueSeq | launchExtra;
			if (launchExtra) begin
				convChannel_q <= extSch;
				convRef_q     <= extraCfg_q[adc_seq_pkg::CFG_SREF_LSB +: 2];
				convDecim_q   <= extraCfg_q[adc_seq_pkg::CFG_SDIV_LSB +: 2];
			end else if (issueSeq) begin
				convChannel_q <= entryCode;
				convRef_q     <= seqCfg_q[adc_seq_pkg::CFG_SREF_LSB +: 2];
				convDecim_q   <= seqCfg_q[adc_seq_pkg::CFG_SDIV_LSB +: 2];
			end
		end
	end

	// Results, DMA triggers and extra-done interrupt
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			result_q      <= '0;
			dmaChanTrig_q <= '0;
			dmaAllTrig_q  <= 1'b0;
			irq_q         <= 1'b0;
		end else begin
			if (seqEnd || extraEnd)
				result_q <= fmtResult;
			dmaChanTrig_q <= '0;
			if (seqEnd && isInternal)
				dmaChanTrig_q[NUM_INPUTS] <= 1'b1;
			else if (seqEnd)
				dmaChanTrig_q[idx_q] <= 1'b1;
			dmaAllTrig_q <= seqEnd;
			irq_q        <= extraEnd;
		end
	end

	// APB answer: access phase lasts two cycles, errors on unmapped offsets
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_q     <= 1'b0;
			pslverr_q    <= 1'b0;
			prdata_q     <= 32'h0;
			enablePrev_q <= '0;
		end else begin
			pready_q     <= accessCyc;
			pslverr_q    <= accessCyc & ~mapped;
			prdata_q     <= (accessCyc && !pwrite) ? {24'h0, rdByte} : 32'h0;
			enablePrev_q <= enable_q;
		end
	end

	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign analogEnable = enable_q;
	assign convStart    = convStart_q;
	assign convChannel  = convChannel_q;
	assign convRef      = convRef_q;
	assign convDecim    = convDecim_q;
	assign dmaChanTrig  = dmaChanTrig_q;
	assign dmaAllTrig   = dmaAllTrig_q;
	assign extraDoneIrq = irq_q;

	a_enable_reset: assert property (
		@(posedge clk) $fell(sys_rst) |-> analogEnable == '0)
		else $error("inputs enabled after reset");

	a_skip_disabled: assert property (
		@(posedge clk) disable iff (sys_rst)
		(convStart && state_q == BUSY_SEQ && convChannel < 4'h8)
			|-> enablePrev_q[convChannel[IDX_W-1:0]])
		else $error("disabled input was converted");

	a_pair_enabled: assert property (
		@(posedge clk) disable iff (sys_rst)
		(convStart && state_q == BUSY_SEQ && convChannel[3:2] == 2'b10)
			|-> enablePrev_q[{convChannel[1:0], 1'b0}]
			&& enablePrev_q[{convChannel[1:0], 1'b1}])
		else $error("pair converted with a pin disabled");

	a_eoc_sets: assert property (
		@(posedge clk) disable iff (sys_rst)
		(convDone && (state_q == BUSY_SEQ || state_q == BUSY_EXTRA))
			|=> eoc_q ##1 (eoc_q || $past(eocClear)))
		else $error("end of conversion flag not set");

	a_start_clears: assert property (
		@(posedge clk) disable iff (sys_rst)
		(seqComplete && !stSet) |=> !st_q)
		else $error("start bit not cleared at sequence end");

	a_one_at_time: assert property (
		@(posedge clk) disable iff (sys_rst)
		(state_q == BUSY_SEQ && !convDone) |=> !convStart)
		else $error("second conversion started while busy");

	a_extra_waits: assert property (
		@(posedge clk) disable iff (sys_rst)
		(extraPend_q && state_q == BUSY_SEQ && convDone && !lastEntry)
			|=> state_q == PICK && !convStart)
		else $error("extra conversion started inside a sequence");

	a_sch_readback: assert property (
		@(posedge clk) disable iff (sys_rst)
		seqEnd |=> schRead_q == readback($past(entryCode)))
		else $error("channel readback wrong");

	a_dma_trigger: assert property (
		@(posedge clk) disable iff (sys_rst)
		seqEnd |=> dmaAllTrig && $onehot(dmaChanTrig) ##1 !dmaAllTrig)
		else $error("dma trigger missing or too long");

	a_irq_extra: assert property (
		@(posedge clk) disable iff (sys_rst)
		extraEnd |=> extraDoneIrq && !dmaAllTrig)
		else $error("extra conversion interrupt wrong");

endmodule

/* File: tb/adc_core_model.sv */
// Behavioural converter core answering each conversion start after a delay
`timescale 1ns/1ps
module adc_core_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Conversion request and pacing
	input  wire logic        convStart,
	input  wire logic [3:0]  convChannel,
	input  wire logic [4:0]  maxWait,
	// Conversion answer
	output logic             convDone,
	output logic [11:0]      convData
);
	logic        busy_q;
	logic [4:0]  left_q;
	logic [3:0]  ch_q;
	logic [11:0] noise_q;

	// Data is only valid with convDone; elsewhere it churns every cycle
	assign convData = convDone ? {ch_q, 8'ha5} : noise_q;

	always_ff @(posedge clk) begin
		convDone <= 1'b0;
		noise_q <= noise_q + 12'h3b1;
		if (sys_rst) begin
			busy_q <= 1'b0;
			noise_q <= 12'h000;
		end else if (convStart) begin
			busy_q <= 1'b1;
			ch_q <= convChannel;
			left_q <= maxWait + 5'($urandom_range(3));
		end else if (busy_q && left_q == 5'd0) begin
			busy_q <= 1'b0;
			convDone <= 1'b1;
		end else if (busy_q) begin
			left_q <= left_q - 5'd1;
		end
	end
endmodule

/* File: tb/adc_conversion_sequencer_tb.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        extStartPin, timerCompare, convStart, convDone;
	logic        dmaAllTrig, extraDoneIrq;
	logic [7:0]  analogEnable;
	logic [3:0]  convChannel;
	logic [1:0]  convRef, convDecim, curSel;
	logic [11:0] convData;
	logic [8:0]  dmaChanTrig, dmaSeen, exMask;
	logic [4:0]  maxWait;
	logic [7:0]  chq[$], exq[$];
	int          nAll, nIrq, err_count, checks_done;

	adc_conversion_sequencer #(.NUM_INPUTS(8)) dut (.clk(clk),
		.sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .extStartPin(extStartPin),
		.timerCompare(timerCompare), .analogEnable(analogEnable),
		.convStart(convStart), .convChannel(convChannel), .convRef(convRef),
		.convDecim(convDecim), .convDone(convDone), .convData(convData),
		.dmaChanTrig(dmaChanTrig), .dmaAllTrig(dmaAllTrig),
		.extraDoneIrq(extraDoneIrq));
	adc_core_model core (.clk(clk), .sys_rst(sys_rst), .convStart(convStart),
		.convChannel(convChannel), .maxWait(maxWait), .convDone(convDone),
		.convData(convData));

	always #25 clk = ~clk;

	always @(posedge clk) begin
		if (!sys_rst) begin
			if (convStart === 1'b1) chq.push_back({convRef, convDecim, convChannel});
			if (dmaAllTrig === 1'b1) nAll++;
			if (extraDoneIrq === 1'b1) nIrq++;
			dmaSeen = dmaSeen | dmaChanTrig;
		end
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0, r, e);
		chk(r, exp);
	endtask

	function automatic void build(input logic [7:0] cfg, input logic [7:0] en);
		exq = {};
		exMask = '0;
		if (cfg[3:0] < 4'h8) begin
			for (int i = 0; i <= int'(cfg[3:0]); i++) begin
				if (en[i]) begin
					exq.push_back({cfg[7:4], 4'(i)});
					exMask[i] = 1'b1;
				end
			end
		end else if (cfg[3:0] < 4'hc) begin
			for (int p = 0; p <= int'(cfg[1:0]); p++) begin
				if (en[2*p] && en[2*p+1]) begin
					exq.push_back({cfg[7:4], 4'(8 + p)});
					exMask[p] = 1'b1;
				end
			end
		end else begin
			exq.push_back(cfg);
			exMask[8] = 1'b1;
		end
	endfunction

	function automatic logic [11:0] expRes(input logic [7:0] c);
		logic [3:0] n;
		case (c[5:4])
			2'd0: n = adc_seq_pkg::RES_SDIV_0;
			2'd1: n = adc_seq_pkg::RES_SDIV_1;
			2'd2: n = adc_seq_pkg::RES_SDIV_2;
			default: n = adc_seq_pkg::RES_SDIV_3;
		endcase
		return {c[3:0], 8'ha5} & (12'hfff << (12 - int'(n)));
	endfunction

	// Bookkeeping is reset between edges so the monitor never races it
	task automatic clear();
		@(negedge clk);
		chq = {};
		nAll = 0;
		nIrq = 0;
		dmaSeen = '0;
	endtask

	task automatic setup(input logic [7:0] cfg, input logic [7:0] en);
		wr(adc_seq_pkg::OFS_INPUT_ENABLE, 32'(en));
		rd(adc_seq_pkg::OFS_INPUT_ENABLE, 32'(en));
		chk(32'(analogEnable), 32'(en));
		wr(adc_seq_pkg::OFS_SEQ_CFG, 32'(cfg));
		build(cfg, en);
		clear();
	endtask

	task automatic waitIdle();
		logic [31:0] r;
		logic        e;
		int          n;
		n = 0;
		do begin
			apb(adc_seq_pkg::OFS_CTRL_STATUS, 1'b0, 32'h0, r, e);
			n++;
		end while ((r[6] | r[0] | (chq.size() < exq.size())) !== 1'b0 && n < 200);
		chk(r & 32'h41, 32'h0);
	endtask

	task automatic verify(input logic [7:0] rb, input int irqs);
		logic [11:0] res;
		logic        eoc;
		eoc = exq.size() > 0;
		chk(32'(chq.size()), 32'(exq.size()));
		foreach (chq[i]) chk(32'(chq[i]), 32'(exq[i]));
		chk(32'(nAll), 32'(exq.size() - irqs));
		chk(32'(dmaSeen), 32'(exMask));
		chk(32'(nIrq), 32'(irqs));
		rd(adc_seq_pkg::OFS_SEQ_CFG, 32'(rb));
		rd(adc_seq_pkg::OFS_CTRL_STATUS, {24'h0, eoc, 1'b0, curSel, 4'h0});
		if (eoc) begin
			res = expRes(exq[$]);
			rd(adc_seq_pkg::OFS_RESULT_HIGH, {24'h0, res[11:4]});
			rd(adc_seq_pkg::OFS_RESULT_LOW, {24'h0, res[3:0], 4'h0});
			rd(adc_seq_pkg::OFS_CTRL_STATUS, {26'h0, curSel, 4'h0});
		end
	endtask

	task automatic pulse(input logic tmr);
		@(posedge clk);
		if (tmr) timerCompare <= 1'b1;
		else extStartPin <= 1'b1;
		@(posedge clk);
		timerCompare <= 1'b0;
		extStartPin <= 1'b0;
	endtask

	initial begin
		#2_000_000;
		err_count++;
		give_verdict();
	end

	initial begin
		logic [31:0] r;
		logic        e;
		logic [7:0]  en, cfg;
		logic [7:0]  xt[2];
		xt = '{8'h9f, 8'h49};
		clk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0;
		paddr = '0; pwdata = '0; extStartPin = 0; timerCompare = 0;
		maxWait = 5'd0; dmaSeen = '0; err_count = 0; checks_done = 0;
		curSel = adc_seq_pkg::START_SOURCE_SELECT_SOFTWARE;
		void'($urandom(32'h7561));
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk(32'(analogEnable), 32'h0);
		rd(adc_seq_pkg::OFS_INPUT_ENABLE, 32'h0);
		rd(adc_seq_pkg::OFS_CTRL_STATUS, 32'h30);
		apb(8'h20, 1'b0, 32'h0, r, e);
		chk(r, 32'h0);
		chk(32'(e), 32'h1);
		// Every channel code once, random reference and rate; no enables for code 0, all for odd codes, random otherwise
		for (int s = 0; s < 16; s++) begin
			en = (s == 0) ? 8'h00 : (s[0] ? 8'hff : 8'($urandom));
			cfg = {4'($urandom), 4'(s)};
			setup(cfg, en);
			wr(adc_seq_pkg::OFS_CTRL_STATUS, 32'h70);
			waitIdle();
			verify(cfg[3:0] < 4'hc ? cfg + 8'h1 : cfg, 0);
		end
		foreach (xt[i]) begin
			clear();
			exq = {xt[i]};
			exMask = '0;
			wr(adc_seq_pkg::OFS_EXTRA_CFG, 32'(xt[i]));
			waitIdle();
			verify({cfg[7:4], xt[i][3:0]}, 1);
		end
		// Extra request lands while a slow sequence is still running
		maxWait <= 5'd20;
		setup(8'h03, 8'hff);
		wr(adc_seq_pkg::OFS_CTRL_STATUS, 32'h70);
		wr(adc_seq_pkg::OFS_EXTRA_CFG, 32'h3e);
		rd(adc_seq_pkg::OFS_CTRL_STATUS, 32'h71);
		exq.push_back(8'h3e);
		waitIdle();
		verify(8'h0e, 1);
		// End of a sequence restarts it while the chained source is chosen
		setup(8'h01, 8'h03);
		wr(adc_seq_pkg::OFS_CTRL_STATUS, 32'h70);
		wr(adc_seq_pkg::OFS_CTRL_STATUS, 32'h50);
		while (chq.size() < 3) @(posedge clk);
		wr(adc_seq_pkg::OFS_CTRL_STATUS, 32'h30);
		exq = {exq, exq};
		waitIdle();
		verify(8'h02, 0);
		maxWait <= 5'd0;
		// Each hardware start source, after the unselected one is ignored
		setup(8'h00, 8'h01);
		for (int k = 0; k < 2; k++) begin
			curSel = k ? adc_seq_pkg::START_SOURCE_SELECT_TIMER : adc_seq_pkg::START_SOURCE_SELECT_EXT_PIN;
			wr(adc_seq_pkg::OFS_CTRL_STATUS, {26'h0, curSel, 4'h0});
			clear();
			pulse(k == 0);
			repeat (10) @(posedge clk);
			chk(32'(chq.size()), 32'h0);
			pulse(k != 0);
			waitIdle();
			verify(8'h01, 0);
		end
		give_verdict();
	end
endmodule
